// ---- logic/shp_consts.svh ----
// constants for the standby halt and register protection block
// ==========================================================
`ifndef SHP_CONSTS_SVH
`define SHP_CONSTS_SVH

// ==========================================================
// register byte offsets
`define SHP_OFF_NOISE 5'h00
`define SHP_OFF_KEY 5'h04
`define SHP_OFF_SC2 5'h08
`define SHP_OFF_CLK 5'h0C
`define SHP_OFF_CS 5'h10
`define SHP_OFF_IDLE 5'h14
`define SHP_OFF_STAT 5'h18

// ==========================================================
// fields and reset values
`define SHP_KEY_VAL 8'h1F
`define SHP_NOISE_PROT_BIT 0
`define SHP_NOISE_RST 4'h3
`define SHP_SC2_HALT_LSB 0
`define SHP_SC2_WARM_LSB 2
`define SHP_HALT_RST 2'h3
`define SHP_WARM_RST 2'h2
`define SHP_CLK_RST 8'h00
`define SHP_CS_RST 32'h00000000
`define SHP_IDLE_RST 11'h000

// ==========================================================
// halt mode codes
`define SHP_MODE_LIGHT 2'h3
`define SHP_MODE_DEEP 2'h2
`define SHP_MODE_STOP 2'h1

// ==========================================================
// interrupt source indices
`define SHP_NSRC 13
`define SHP_SRC_NMI 0
`define SHP_SRC_WDT 1
`define SHP_SRC_EXT_LO 2
`define SHP_SRC_EXT_HI 6
`define SHP_SRC_RTC 7
`define SHP_SRC_TAE_LO 8
`define SHP_SRC_TAE_HI 11
`define SHP_TAE_MASK 13'h0F00
`define SHP_NMI_LVL 3'h7
`define SHP_IDLE_TB1 4
`define SHP_IDLE_TB2 5

// ==========================================================
// timing in fast peripheral clocks and oscillator clocks
`define SHP_ENTRY_CLKS 5
`define SHP_ENTRY_CYC 17'h00005
`define SHP_WARM_LO_CYC 256
`define SHP_WARM_MID_CYC 16384
`define SHP_WARM_HI_CYC 65536

`endif

// ---- logic/shp_pkg.sv ----
// types for the standby halt and register protection block
package shp_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_ENTER = 3'b001,
    ST_LIGHT = 3'b010,
    ST_DEEP = 3'b011,
    ST_STOP = 3'b100,
    ST_WAKE = 3'b101
  } shp_state_t;
endpackage : shp_pkg

// ---- logic/shp_standby.sv ----
// standby halt controller with key-locked configuration registers
`timescale 1ns/10ps
`include "shp_consts.svh"

module shp_standby #(
  parameter int unsigned WARM_MID_CYC = `SHP_WARM_MID_CYC,
  parameter int unsigned WARM_HI_CYC = `SHP_WARM_HI_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic haltReq,
  input wire logic [12:0] irqReq,
  input wire logic [35:0] irqLevels,
  input wire logic [2:0] interruptMaskLevel,
  output logic cpuRun,
  output logic sysClkEn,
  output logic oscEn,
  output logic clockTimerEn,
  output logic [10:0] periphClkEn,
  output logic portHold,
  output logic wakePulse,
  output logic [3:0] wakeId,
  output logic wakeServe,
  output logic wake2Valid,
  output logic [3:0] wake2Id,
  output logic wake2Serve,
  output logic [7:0] clockCfg,
  output logic [31:0] chipSelCfg
);

  // ==========================================================
  // state
  shp_pkg::shp_state_t state_q;
  logic [1:0] holdMode_q;
  logic [16:0] cnt_q;
  logic fromStop_q;
  logic lock_q;
  logic [3:0] noiseBits_q;
  logic [1:0] haltMode_q;
  logic [1:0] warmSel_q;
  logic [10:0] idleEn_q;
  logic pendV_q;
  logic [3:0] pendId_q;
  logic [2:0] pendLvl_q;
  logic pendServe_q;
  logic [3:0] winId_q;
  logic [2:0] winLvl_q;
  logic winServe_q;
  logic wrEn;
  logic wrOpen;
  logic [31:0] rdMux;
  logic [16:0] warmCyc;
  logic [1:0] evMode;
  logic wFound;
  logic [3:0] wId;
  logic [2:0] wLvl;
  logic wServe;
  logic asleep;
  logic exitNow;
  logic pendFirst;

  // ==========================================================
  // avalon slave: one wait cycle per access
  assign wrEn = avs_write & ~avs_waitrequest;
  assign wrOpen = wrEn & ~lock_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rdMux = 32'h00000000;
    case (avs_address)
      `SHP_OFF_NOISE: rdMux = {27'h0000000, noiseBits_q, lock_q};
      `SHP_OFF_SC2: rdMux = {28'h0000000, warmSel_q, haltMode_q};
      `SHP_OFF_CLK: rdMux = {24'h000000, clockCfg};
      `SHP_OFF_CS: rdMux = chipSelCfg;
      `SHP_OFF_IDLE: rdMux = {21'h000000, idleEn_q};
      `SHP_OFF_STAT: rdMux = {23'h000000, lock_q, pendId_q, pendV_q, state_q};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= rdMux;
    end
  end

  // ==========================================================
  // key lock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
    end else if (wrEn && avs_address == `SHP_OFF_KEY) begin
      lock_q <= (avs_writedata[7:0] != `SHP_KEY_VAL);
    end
  end

  // ==========================================================
  // protected configuration, wake never touches these; the idle enable register below is not key-locked
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      noiseBits_q <= `SHP_NOISE_RST;
      haltMode_q <= `SHP_HALT_RST;
      warmSel_q <= `SHP_WARM_RST;
      clockCfg <= `SHP_CLK_RST;
      chipSelCfg <= `SHP_CS_RST;
    end else begin
      if (wrOpen && avs_address == `SHP_OFF_NOISE) begin
        noiseBits_q <= avs_writedata[4:1];
      end
      if (wrOpen && avs_address == `SHP_OFF_SC2) begin
        haltMode_q <= avs_writedata[`SHP_SC2_HALT_LSB +: 2];
        warmSel_q <= avs_writedata[`SHP_SC2_WARM_LSB +: 2];
      end
      if (wrOpen && avs_address == `SHP_OFF_CLK) begin
        clockCfg <= avs_writedata[7:0];
      end
      if (wrOpen && avs_address == `SHP_OFF_CS) begin
        chipSelCfg <= avs_writedata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idleEn_q <= `SHP_IDLE_RST;
    end else if (wrEn && avs_address == `SHP_OFF_IDLE) begin
      idleEn_q <= avs_writedata[10:0];
    end
  end

  // ==========================================================
  // wake evaluation
  always_comb begin
    case (warmSel_q)
      2'h2: warmCyc = WARM_MID_CYC[16:0];
      2'h3: warmCyc = WARM_HI_CYC[16:0];
      default: warmCyc = 17'(`SHP_WARM_LO_CYC);
    endcase
  end

  always_comb begin
    case (state_q)
      shp_pkg::ST_LIGHT: evMode = `SHP_MODE_LIGHT;
      shp_pkg::ST_DEEP: evMode = `SHP_MODE_DEEP;
      shp_pkg::ST_STOP: evMode = `SHP_MODE_STOP;
      shp_pkg::ST_ENTER: evMode = holdMode_q;
      default: evMode = 2'h0;
    endcase
  end

  always_comb begin
    logic [2:0] lv;
    logic isExt;
    logic isTae;
    logic isRtc;
    logic isNmi;
    logic el;
    logic sv;
    lv = 3'h0;
    isExt = 1'b0;
    isTae = 1'b0;
    isRtc = 1'b0;
    isNmi = 1'b0;
    el = 1'b0;
    sv = 1'b0;
    wFound = 1'b0;
    wId = 4'h0;
    wLvl = 3'h0;
    wServe = 1'b0;
    for (int i = 0; i < `SHP_NSRC; i++) begin
      isNmi = (i == `SHP_SRC_NMI);
      isExt = (i >= `SHP_SRC_EXT_LO) && (i <= `SHP_SRC_EXT_HI);
      isTae = (i >= `SHP_SRC_TAE_LO) && (i <= `SHP_SRC_TAE_HI);
      isRtc = (i == `SHP_SRC_RTC);
      lv = isNmi ? `SHP_NMI_LVL : irqLevels[3 * ((i == 0) ? 0 : i - 1) +: 3];
      case (evMode)
        `SHP_MODE_LIGHT: el = !isTae || (idleEn_q[`SHP_IDLE_TB1]
                              && idleEn_q[`SHP_IDLE_TB2]);
        `SHP_MODE_DEEP: el = isNmi || isExt || isRtc;
        `SHP_MODE_STOP: el = isNmi || isExt;
        default: el = 1'b0;
      endcase
      sv = isNmi || (lv >= interruptMaskLevel);
      // masked external/clock timer wake without service
      if (irqReq[i] && el && (sv || isExt || isRtc)
          && (!wFound || lv > wLvl)) begin
        wFound = 1'b1;
        wId = 4'(i);
        wLvl = lv;
        wServe = sv;
      end
    end
  end

  assign asleep = (state_q == shp_pkg::ST_LIGHT) || (state_q == shp_pkg::ST_DEEP)
                  || (state_q == shp_pkg::ST_STOP);
  assign exitNow = (state_q == shp_pkg::ST_WAKE) && (cnt_q == 17'h00000);
  assign pendFirst = pendV_q && (pendLvl_q > winLvl_q);

  // ==========================================================
  // halt state machine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= shp_pkg::ST_RUN;
      holdMode_q <= 2'h0;
      cnt_q <= 17'h00000;
      fromStop_q <= 1'b0;
    end else begin
      case (state_q)
        shp_pkg::ST_RUN: begin
          if (haltReq) begin
            case (haltMode_q)
              `SHP_MODE_LIGHT: state_q <= shp_pkg::ST_LIGHT;
              `SHP_MODE_DEEP, `SHP_MODE_STOP: begin
                state_q <= shp_pkg::ST_ENTER;
                holdMode_q <= haltMode_q;
                cnt_q <= `SHP_ENTRY_CYC - 17'h00001;
              end
              default: state_q <= shp_pkg::ST_RUN;
            endcase
          end
        end
        shp_pkg::ST_ENTER: begin
          // requests here only go pending
          if (cnt_q == 17'h00000) begin
            state_q <= (holdMode_q == `SHP_MODE_DEEP) ? shp_pkg::ST_DEEP
                                                      : shp_pkg::ST_STOP;
          end else begin
            cnt_q <= cnt_q - 17'h00001;
          end
        end
        shp_pkg::ST_LIGHT, shp_pkg::ST_DEEP: begin
          if (wFound) begin
            state_q <= shp_pkg::ST_WAKE;
            cnt_q <= 17'h00000;
            fromStop_q <= 1'b0;
          end
        end
        shp_pkg::ST_STOP: begin
          if (wFound) begin
            state_q <= shp_pkg::ST_WAKE;
            cnt_q <= warmCyc - 17'h00001;
            fromStop_q <= 1'b1;
          end
        end
        shp_pkg::ST_WAKE: begin
          if (cnt_q == 17'h00000) begin
            state_q <= shp_pkg::ST_RUN;
          end else begin
            cnt_q <= cnt_q - 17'h00001;
          end
        end
        default: state_q <= shp_pkg::ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // pending request caught during entry
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pendV_q <= 1'b0;
      pendId_q <= 4'h0;
      pendLvl_q <= 3'h0;
      pendServe_q <= 1'b0;
    end else if (state_q == shp_pkg::ST_ENTER && wFound
                 && (!pendV_q || wLvl > pendLvl_q)) begin
      pendV_q <= 1'b1;
      pendId_q <= wId;
      pendLvl_q <= wLvl;
      pendServe_q <= wServe;
    end else if (exitNow) begin
      pendV_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      winId_q <= 4'h0;
      winLvl_q <= 3'h0;
      winServe_q <= 1'b0;
    end else if (asleep && wFound) begin
      winId_q <= wId;
      winLvl_q <= wLvl;
      winServe_q <= wServe;
    end
  end

  // ==========================================================
  // wake report to cpu and interrupt controller
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wakePulse <= 1'b0;
      wakeId <= 4'h0;
      wakeServe <= 1'b0;
      wake2Valid <= 1'b0;
      wake2Id <= 4'h0;
      wake2Serve <= 1'b0;
    end else begin
      wakePulse <= exitNow;
      if (exitNow) begin
        wakeId <= pendFirst ? pendId_q : winId_q;
        wakeServe <= pendFirst ? pendServe_q : winServe_q;
        wake2Valid <= pendV_q;
        wake2Id <= pendFirst ? winId_q : pendId_q;
        wake2Serve <= pendFirst ? winServe_q : pendServe_q;
      end
    end
  end

  // ==========================================================
  // clock enables and port hold
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cpuRun <= 1'b1;
      sysClkEn <= 1'b1;
      oscEn <= 1'b1;
      clockTimerEn <= 1'b1;
      periphClkEn <= 11'h7FF;
      portHold <= 1'b0;
    end else begin
      cpuRun <= (state_q == shp_pkg::ST_RUN);
      sysClkEn <= !((state_q == shp_pkg::ST_DEEP) || (state_q == shp_pkg::ST_STOP)
                    || (state_q == shp_pkg::ST_WAKE && fromStop_q));
      oscEn <= (state_q != shp_pkg::ST_STOP);
      clockTimerEn <= !((state_q == shp_pkg::ST_STOP)
                        || (state_q == shp_pkg::ST_WAKE && fromStop_q));
      if (state_q == shp_pkg::ST_RUN || state_q == shp_pkg::ST_ENTER) begin
        periphClkEn <= 11'h7FF;
      end else if (state_q == shp_pkg::ST_LIGHT) begin
        periphClkEn <= idleEn_q;
      end else begin
        periphClkEn <= 11'h000;
      end
      portHold <= (state_q != shp_pkg::ST_RUN);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_keyLock;
    wrEn && avs_address == `SHP_OFF_KEY && avs_writedata[7:0] != `SHP_KEY_VAL
      |=> lock_q ##1 lock_q || wrEn;
  endproperty
  a_keyLock: assert property (p_keyLock) else $error("bad key did not lock");

  property p_keyUnlock;
    wrEn && avs_address == `SHP_OFF_KEY && avs_writedata[7:0] == `SHP_KEY_VAL
      |=> !lock_q;
  endproperty
  a_keyUnlock: assert property (p_keyUnlock) else $error("key did not unlock");

  property p_status;
    avs_read && avs_waitrequest && avs_address == `SHP_OFF_NOISE
      |=> !avs_waitrequest && avs_readdata[`SHP_NOISE_PROT_BIT] == $past(lock_q);
  endproperty
  a_status: assert property (p_status) else $error("lock status misread");

  property p_rstOff;
    disable iff (1'b0) sys_rst |=> !lock_q && state_q == shp_pkg::ST_RUN;
  endproperty
  a_rstOff: assert property (p_rstOff) else $error("reset left lock or halt");

  property p_protDiscard;
    wrEn && lock_q && (avs_address == `SHP_OFF_SC2 || avs_address == `SHP_OFF_CS)
      |=> $stable(haltMode_q) && $stable(warmSel_q) && $stable(chipSelCfg);
  endproperty
  a_protDiscard: assert property (p_protDiscard) else $error("locked write landed");

  property p_light;
    state_q == shp_pkg::ST_RUN && haltReq && haltMode_q == `SHP_MODE_LIGHT
      |=> state_q == shp_pkg::ST_LIGHT ##1 !cpuRun;
  endproperty
  a_light: assert property (p_light) else $error("light idle not entered");

  sequence s_haltDeep;
    state_q == shp_pkg::ST_RUN && haltReq && haltMode_q == `SHP_MODE_DEEP;
  endsequence
  sequence s_entryDeep;
    (state_q == shp_pkg::ST_ENTER)[*5] ##1 state_q == shp_pkg::ST_DEEP;
  endsequence
  property p_entry;
    s_haltDeep |=> s_entryDeep;
  endproperty
  a_entry: assert property (p_entry) else $error("deep entry period wrong");

  property p_deep;
    state_q == shp_pkg::ST_DEEP |=> oscEn && clockTimerEn && !sysClkEn
      && periphClkEn == 11'h000 && portHold;
  endproperty
  a_deep: assert property (p_deep) else $error("deep idle clocks wrong");

  property p_stop;
    state_q == shp_pkg::ST_STOP |=> !oscEn && !clockTimerEn && !sysClkEn;
  endproperty
  a_stop: assert property (p_stop) else $error("stop kept a clock");

  property p_nmi;
    state_q == shp_pkg::ST_LIGHT && irqReq[`SHP_SRC_NMI]
      |=> state_q == shp_pkg::ST_WAKE ##1 wakePulse && wakeServe && wakeId == 4'h0;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi failed to wake");

  property p_warm;
    state_q == shp_pkg::ST_STOP && wFound
      |=> state_q == shp_pkg::ST_WAKE && fromStop_q && cnt_q == $past(warmCyc) - 17'h00001;
  endproperty
  a_warm: assert property (p_warm) else $error("stop wake skipped warm-up");

  property p_taeGate;
    state_q == shp_pkg::ST_LIGHT && (irqReq & ~`SHP_TAE_MASK) == 13'h0000
      && !idleEn_q[`SHP_IDLE_TB1] |=> state_q == shp_pkg::ST_LIGHT;
  endproperty
  a_taeGate: assert property (p_taeGate) else $error("timer irq woke ungated");

endmodule : shp_standby

// ---- verif/shp_cpu_model.sv ----
// cpu core and interrupt controller request flags facing the standby block
`timescale 1ns/10ps

module shp_cpu_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [12:0] raiseIrq,
  input wire logic [12:0] dropIrq,
  input wire logic wakePulse,
  input wire logic [3:0] wakeId,
  input wire logic wakeServe,
  input wire logic wake2Valid,
  input wire logic [3:0] wake2Id,
  input wire logic wake2Serve,
  output logic [12:0] irqReq
);
  logic [12:0] ackMask;

  // ==========================================================
  // start of service acknowledges a flag; resume without service keeps it
  always_comb begin
    ackMask = 13'h0000;
    if (wakePulse && wakeServe) begin
      ackMask[wakeId] = 1'b1;
    end
    if (wakePulse && wake2Valid && wake2Serve) begin
      ackMask[wake2Id] = 1'b1;
    end
  end

  // ==========================================================
  // request lines held high until service starts or dropIrq clears them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqReq <= 13'h0000;
    end else begin
      irqReq <= (irqReq | raiseIrq) & ~dropIrq & ~ackMask;
    end
  end
endmodule : shp_cpu_model

// ---- verif/shp_standby_bench.sv ----
// self-checking bench for the standby halt and register lock block
`timescale 1ns/10ps
`include "shp_consts.svh"

module shp_standby_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, haltReq = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [12:0] raiseIrq = 13'h0000, dropIrq = 13'h0000, irqReq;
  logic [35:0] irqLevels = 36'h000000000;
  logic [2:0] interruptMaskLevel = 3'h0;
  logic [31:0] avs_readdata, chipSelCfg, rd;
  logic avs_waitrequest, cpuRun, sysClkEn, oscEn, clockTimerEn, portHold;
  logic wakePulse, wakeServe, wake2Valid, wake2Serve;
  logic [3:0] wakeId, wake2Id;
  logic [10:0] periphClkEn;
  logic [7:0] clockCfg;
  int error_cnt = 0;
  int check_count = 0;
  int n;

  always #50 sys_clk = ~sys_clk;

  shp_standby #(.WARM_MID_CYC(20), .WARM_HI_CYC(40)) dut (
    .sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .haltReq, .irqReq, .irqLevels,
    .interruptMaskLevel, .cpuRun, .sysClkEn, .oscEn, .clockTimerEn, .periphClkEn,
    .portHold, .wakePulse, .wakeId, .wakeServe, .wake2Valid, .wake2Id, .wake2Serve,
    .clockCfg, .chipSelCfg
  );

  shp_cpu_model cpu (
    .sys_clk, .sys_rst, .raiseIrq, .dropIrq, .wakePulse, .wakeId, .wakeServe,
    .wake2Valid, .wake2Id, .wake2Serve, .irqReq
  );

  // ==========================================================
  // report and shared tasks
  task stop_test;
    $display("mismatches %0d of %0d checks", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick

  task acc(input logic isRd, input logic [4:0] a, input logic [31:0] d);
    int w;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= isRd;
    avs_write <= !isRd;
    w = 0;
    do begin
      @(posedge sys_clk);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w >= 40) begin
      error_cnt++;
      stop_test();
    end
  endtask : acc

  task wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b0, a, d);
  endtask : wr

  task rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    acc(1'b1, a, 32'h00000000);
    chk(nm, e, rd);
  endtask : rdc

  task halt;
    @(posedge sys_clk);
    haltReq <= 1'b1;
    @(posedge sys_clk);
    haltReq <= 1'b0;
  endtask : halt

  task irq(input logic [12:0] r, input logic [12:0] d);
    @(posedge sys_clk);
    raiseIrq <= r;
    dropIrq <= d;
    @(posedge sys_clk);
    raiseIrq <= 13'h0000;
    dropIrq <= 13'h0000;
  endtask : irq

  task wait_wake;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wakePulse !== 1'b1 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      stop_test();
    end
  endtask : wait_wake

  function automatic logic [35:0] lv(input int i, input logic [2:0] v);
    lv = 36'h000000000;
    lv[3*(i-1)+:3] = v;
  endfunction : lv

  // ==========================================================
  // tests
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    tick(1);
    chk("outs", 32'h0000001E, {cpuRun, sysClkEn, oscEn, clockTimerEn, portHold});
    chk("periph", 32'h000007FF, periphClkEn);
    rdc("noise", `SHP_OFF_NOISE, 32'h00000006);
    rdc("sc2", `SHP_OFF_SC2, 32'h0000000B);
    rdc("stat", `SHP_OFF_STAT, 32'h00000000);
    rdc("unmapped", 5'h1C, 32'h00000000);
    $display("test reset done");

    wr(`SHP_OFF_KEY, 32'h00000000);
    rdc("noise", `SHP_OFF_NOISE, 32'h00000007);
    rdc("stat", `SHP_OFF_STAT, 32'h00000100);
    wr(`SHP_OFF_CLK, 32'h000000A5);
    wr(`SHP_OFF_CS, 32'hDEADBEEF);
    wr(`SHP_OFF_SC2, 32'h00000001);
    wr(`SHP_OFF_NOISE, 32'h0000001E);
    wr(`SHP_OFF_IDLE, 32'h00000030);
    tick(1);
    chk("clk", 32'h00000000, clockCfg);
    chk("cs", 32'h00000000, chipSelCfg);
    rdc("sc2", `SHP_OFF_SC2, 32'h0000000B);
    rdc("noise", `SHP_OFF_NOISE, 32'h00000007);
    rdc("idle", `SHP_OFF_IDLE, 32'h00000030);
    wr(`SHP_OFF_KEY, 32'h0000001F);
    wr(`SHP_OFF_CLK, 32'h0000005A);
    wr(`SHP_OFF_CS, 32'h12345678);
    tick(1);
    chk("clk", 32'h0000005A, clockCfg);
    chk("cs", 32'h12345678, chipSelCfg);
    rdc("stat", `SHP_OFF_STAT, 32'h00000000);
    $display("test lock done");

    interruptMaskLevel <= 3'h5;
    irqLevels <= lv(1, 3'h3) | lv(8, 3'h7);
    halt();
    tick(4);
    chk("cpu", 32'h00000000, cpuRun);
    chk("sysclk", 32'h00000001, sysClkEn);
    chk("periph", 32'h00000030, periphClkEn);
    chk("hold", 32'h00000001, portHold);
    rdc("stat", `SHP_OFF_STAT, 32'h00000002);
    irq(13'h0002, 13'h0000);
    tick(8);
    chk("cpu", 32'h00000000, cpuRun);
    wr(`SHP_OFF_IDLE, 32'h00000020);
    irq(13'h0100, 13'h0002);
    tick(6);
    chk("cpu", 32'h00000000, cpuRun);
    wr(`SHP_OFF_IDLE, 32'h00000030);
    wait_wake();
    chk("id", 32'h00000008, wakeId);
    chk("serve", 32'h00000001, wakeServe);
    tick(2);
    chk("cpu", 32'h00000001, cpuRun);
    chk("periph", 32'h000007FF, periphClkEn);
    chk("clk", 32'h0000005A, clockCfg);
    interruptMaskLevel <= 3'h7;
    halt();
    tick(4);
    irq(13'h0001, 13'h0000);
    wait_wake();
    chk("id", 32'h00000000, wakeId);
    chk("serve", 32'h00000001, wakeServe);
    $display("test light done");

    wr(`SHP_OFF_SC2, 32'h0000000A);
    interruptMaskLevel <= 3'h5;
    irqLevels <= 36'h249249249 | lv(1, 3'h7);
    for (int s = 2; s <= 7; s++) begin
      halt();
      tick(10);
      chk("deep", 32'h00000003, {sysClkEn, oscEn, clockTimerEn});
      chk("periph", 32'h00000000, periphClkEn);
      chk("hold", 32'h00000001, portHold);
      irq(13'h0002, 13'h0000);
      tick(6);
      chk("cpu", 32'h00000000, cpuRun);
      irq(13'h0001 << s, 13'h0002);
      wait_wake();
      chk("id", s, wakeId);
      chk("serve", 32'h00000000, wakeServe);
      chk("flag", 32'h00000001, irqReq[s]);
      irq(13'h0000, 13'h0001 << s);
    end
    $display("test deep done");

    wr(`SHP_OFF_SC2, 32'h00000009);
    interruptMaskLevel <= 3'h2;
    irqLevels <= lv(7, 3'h4) | lv(3, 3'h6);
    halt();
    tick(10);
    chk("stop", 32'h00000000, {sysClkEn, oscEn, clockTimerEn});
    irq(13'h0080, 13'h0000);
    tick(8);
    chk("cpu", 32'h00000000, cpuRun);
    irq(13'h0008, 13'h0080);
    wait_wake();
    chk("warm", 32'h00000001, n >= 20 && n <= 24);
    chk("id", 32'h00000003, wakeId);
    chk("serve", 32'h00000001, wakeServe);
    $display("test stop done");

    wr(`SHP_OFF_SC2, 32'h0000000A);
    interruptMaskLevel <= 3'h0;
    irqLevels <= lv(2, 3'h2) | lv(4, 3'h6);
    halt();
    irq(13'h0004, 13'h0000);
    irq(13'h0000, 13'h0004);
    tick(8);
    chk("cpu", 32'h00000000, cpuRun);
    rdc("stat", `SHP_OFF_STAT, 32'h0000002B);
    irq(13'h0010, 13'h0000);
    wait_wake();
    chk("id", 32'h00000004, wakeId);
    chk("second", 32'h00000012, {wake2Valid, wake2Id});
    chk("serve2", 32'h00000001, wake2Serve);
    $display("test pending done");

    wr(`SHP_OFF_SC2, 32'h00000008);
    halt();
    tick(3);
    chk("cpu", 32'h00000001, cpuRun);
    wr(`SHP_OFF_SC2, 32'h0000000B);
    halt();
    tick(4);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(2);
    chk("outs", 32'h0000001E, {cpuRun, sysClkEn, oscEn, clockTimerEn, portHold});
    chk("clk", 32'h00000000, clockCfg);
    rdc("sc2", `SHP_OFF_SC2, 32'h0000000B);
    $display("test reset in halt done");
    stop_test();
  end
endmodule : shp_standby_bench
